// ### design/adc_slave_defs.vh
`ifndef ADC_SLAVE_DEFS_VH
`define ADC_SLAVE_DEFS_VH

// Fixed seven-bit slave addresses of the two variants
`define ADDR_FOUR_CH 7'h64
`define ADDR_TWELVE_CH 7'h65

// High-speed master code: top five bits 0000_1, low three ignored
`define MCODE_TOP 5'h01
`define MCODE_HI 7
`define MCODE_LO 3

// Control byte type flag
`define BYTE_TYPE_BIT 7

// Setup byte field positions
`define SETUP_SEL_HI 6
`define SETUP_SEL_LO 4
`define SETUP_CLK_BIT 3
`define SETUP_POL_BIT 2
`define SETUP_RST_BIT 1

// Configuration byte field positions
`define CFG_SCAN_HI 6
`define CFG_SCAN_LO 5
`define CFG_CS_HI 4
`define CFG_CS_LO 1
`define CFG_MODE_BIT 0

// Power-up values
`define SEL_RESET 3'h0
`define CLK_RESET 1'h0
`define POL_RESET 1'h0
`define SCAN_RESET 2'h0
`define CS_RESET 4'h0
`define MODE_RESET 1'h0

// Bit counter landmarks within a nine-clock byte
`define BIT_FIRST 4'h0
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
// Loaded by START; the clock fall that closes START is not a data bit
`define BIT_PRE_START 4'hf

// Result coding limits
`define CODE_ZERO 8'h00
`define CODE_POS_MAX 8'h7f
`define CODE_NEG_MAX 8'h80

`endif

// ### design/result_coder.v
`timescale 1ns/1ps
// Turns the signed difference sample into the 8-bit output code
module result_coder (
    input wire [8:0] sample_i,
    input wire input_mode_i,
    input wire polarity_i,
    output reg [7:0] code_o
);
`include "adc_slave_defs.vh"

    // Sign and overflow flags of the two's complement sample
    wire neg_w;
    wire pos_over_w;
    wire neg_over_w;
    // Effective polarity after the single-ended override
    wire bipolar_w;

    assign neg_w = sample_i[8];
    assign pos_over_w = ~sample_i[8] & sample_i[7];
    assign neg_over_w = sample_i[8] & ~sample_i[7];
    assign bipolar_w = polarity_i & ~input_mode_i;

    // Code selection; the sample already is channel minus ground or plus minus minus
    always @* begin
        code_o = sample_i[7:0];
        if (bipolar_w) begin
            // Clamp to the signed eight-bit span
            if (pos_over_w) begin
                code_o = `CODE_POS_MAX;
            end else if (neg_over_w) begin
                code_o = `CODE_NEG_MAX;
            end
        end else begin
            if (neg_w) begin
                code_o = `CODE_ZERO;
            end
        end
    end

endmodule // result_coder

// ### design/adc_two_wire_slave_setup.v
// Functional notes
// - Setup bits 6-4 select reference, reset 000
// - Setup bit 1 zero resets configuration only
// - Setup bit 0 is ignored
// - Input mode picks ground or differential reference
// - Unipolar straight binary, bipolar two's complement
// - Unipolar negative difference codes as zero
// - Single-ended always forces unipolar coding
// - One bit per clock, nine clocks per byte
// - Data change while clock high is control
// - Detect START and STOP conditions
// - Repeated START keeps session and timing mode
// - Acknowledge drives data low on ninth clock
// - Not-acknowledge leaves data high on ninth clock
// - Match fixed seven-bit address, ignore others
// - Address LSB is direction, one reads
// - Acknowledge address for the ninth clock
// - Power up in fast/standard bus timing
// - Lines idle high, clock up to 1.7MHz
// - One or two control bytes, each acknowledged
// - Master code not-acknowledged, enters high speed
// - Release data on master not-acknowledge
`timescale 1ns/1ps
module adc_two_wire_slave_setup #(
    // Zero selects the four-channel address, one the twelve-channel one
    parameter TWELVE_CH = 0
) (
    input wire clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire [8:0] sample_i,
    output reg [2:0] ref_select_o,
    output reg ext_clock_sel_o,
    output reg polarity_select_o,
    output reg [1:0] scan_mode_o,
    output reg [3:0] chan_select_o,
    output reg input_mode_select_o,
    output reg hs_mode_o,
    output reg read_active_o
);
`include "adc_slave_defs.vh"

    // One-hot bus states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_WRITE = 5'h04;
    localparam [4:0] ST_READ = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    // Own address chosen by variant
    localparam [6:0] OWN_ADDR = (TWELVE_CH != 0) ? `ADDR_TWELVE_CH : `ADDR_FOUR_CH;

    // Two-stage synchronisers; the first stage feeds only the second
    reg scl_meta_ff;
    reg sda_meta_ff;
    reg scl_sync_ff;
    reg sda_sync_ff;
    // Previous synchronised levels for edge finding
    reg scl_prev_ff;
    reg sda_prev_ff;

    // Protocol state
    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [3:0] bit_cnt_ff;
    reg [3:0] nxt_bit_cnt;
    reg [7:0] rx_ff;
    reg [7:0] nxt_rx;
    reg [7:0] tx_ff;
    reg [7:0] nxt_tx;
    // Address byte outcome, held over the ninth clock
    reg addr_hit_ff;
    reg nxt_addr_hit;
    reg addr_read_ff;
    reg nxt_addr_read;
    reg mcode_ff;
    reg nxt_mcode;
    // Master answer sampled on the ninth rise of a read byte
    reg master_nack_ff;
    reg nxt_master_nack;
    reg nxt_sda_oe;
    reg nxt_hs_mode;

    // Setup and configuration fields
    reg [2:0] nxt_ref_select;
    reg nxt_ext_clock;
    reg nxt_polarity;
    reg [1:0] nxt_scan_mode;
    reg [3:0] nxt_chan_select;
    reg nxt_input_mode;

    // Bus events seen at the block clock
    wire scl_rise_w;
    wire scl_fall_w;
    wire start_w;
    wire stop_w;
    // Coded result of the present sample
    wire [7:0] code_w;

    assign scl_rise_w = scl_sync_ff & ~scl_prev_ff;
    assign scl_fall_w = ~scl_sync_ff & scl_prev_ff;
    // data edge with clock high is control
    // falling data is START, rising is STOP
    assign start_w = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
    assign stop_w = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

    // sample is channel to ground or plus to minus, per input mode
    result_coder u_coder (
        .sample_i(sample_i),
        .input_mode_i(input_mode_select_o),
        .polarity_i(polarity_select_o),
        .code_o(code_w)
    );

    // Address match test on a completed address byte
    function addr_match;
        input [7:0] byte_in;
        begin
            addr_match = (byte_in[7:1] == OWN_ADDR);
        end
    endfunction

    // Pin sampling; the lines come from outside the clock domain
    always @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= scl_i;
            sda_meta_ff <= sda_i;
            scl_sync_ff <= scl_meta_ff;
            sda_sync_ff <= sda_meta_ff;
            scl_prev_ff <= scl_sync_ff;
            sda_prev_ff <= sda_sync_ff;
        end
    end

    // Next-state logic of the byte engine and the control fields
    always @* begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_addr_hit = addr_hit_ff;
        nxt_addr_read = addr_read_ff;
        nxt_mcode = mcode_ff;
        nxt_master_nack = master_nack_ff;
        nxt_sda_oe = sda_oe_o;
        nxt_hs_mode = hs_mode_o;
        nxt_ref_select = ref_select_o;
        nxt_ext_clock = ext_clock_sel_o;
        nxt_polarity = polarity_select_o;
        nxt_scan_mode = scan_mode_o;
        nxt_chan_select = chan_select_o;
        nxt_input_mode = input_mode_select_o;
        if (stop_w) begin
            // STOP ends the session and drops back to fast/standard timing
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
            nxt_hs_mode = 1'b0;
        end else if (start_w) begin
            // restart address recognition from bit one
            // repeated START keeps the timing mode
            nxt_state = ST_ADDR;
            // The fall after START wraps the count to the first bit
            nxt_bit_cnt = `BIT_PRE_START;
            nxt_sda_oe = 1'b0;
        end else if (scl_rise_w) begin
            // one bit taken per clock rise
            if ((state_ff == ST_ADDR) || (state_ff == ST_WRITE)) begin
                if (bit_cnt_ff != `BIT_ACK) begin
                    nxt_rx = {rx_ff[6:0], sda_sync_ff};
                end
            end else if (state_ff == ST_READ) begin
                if (bit_cnt_ff == `BIT_ACK) begin
                    nxt_master_nack = sda_sync_ff;
                end
            end
        end else if (scl_fall_w) begin
            if (bit_cnt_ff == `BIT_LAST) begin
                // Eighth bit done; the ninth clock carries the answer
                nxt_bit_cnt = `BIT_ACK;
                case (state_ff)
                    ST_ADDR: begin
                        // only the own address is answered
                        nxt_addr_hit = addr_match(rx_ff);
                        nxt_addr_read = rx_ff[0];
                        nxt_mcode = (rx_ff[`MCODE_HI:`MCODE_LO] == `MCODE_TOP);
                        // address acknowledge for the ninth clock
                        nxt_sda_oe = addr_match(rx_ff);
                    end
                    ST_WRITE: begin
                        // data held low through the ninth clock
                        nxt_sda_oe = 1'b1;
                        if (rx_ff[`BYTE_TYPE_BIT]) begin
                            nxt_ref_select = rx_ff[`SETUP_SEL_HI:`SETUP_SEL_LO];
                            nxt_ext_clock = rx_ff[`SETUP_CLK_BIT];
                            nxt_polarity = rx_ff[`SETUP_POL_BIT];
                            // bit 0 is not looked at
                            if (!rx_ff[`SETUP_RST_BIT]) begin
                                nxt_scan_mode = `SCAN_RESET;
                                nxt_chan_select = `CS_RESET;
                                nxt_input_mode = `MODE_RESET;
                            end
                        end else begin
                            // scan, channel and input mode fields
                            nxt_scan_mode = rx_ff[`CFG_SCAN_HI:`CFG_SCAN_LO];
                            nxt_chan_select = rx_ff[`CFG_CS_HI:`CFG_CS_LO];
                            nxt_input_mode = rx_ff[`CFG_MODE_BIT];
                        end
                    end
                    ST_READ: begin
                        // release so the master answers on the ninth clock
                        nxt_sda_oe = 1'b0;
                    end
                    default: begin
                        nxt_sda_oe = 1'b0;
                    end
                endcase
            end else if (bit_cnt_ff == `BIT_ACK) begin
                // Ninth clock over: start the next byte
                nxt_bit_cnt = `BIT_FIRST;
                case (state_ff)
                    ST_ADDR: begin
                        if (addr_hit_ff && addr_read_ff) begin
                            // First data bit goes out at once
                            nxt_state = ST_READ;
                            nxt_tx = code_w;
                            nxt_sda_oe = ~code_w[7];
                        end else if (addr_hit_ff) begin
                            nxt_state = ST_WRITE;
                            nxt_sda_oe = 1'b0;
                        end else begin
                            // master code switches to high speed
                            if (mcode_ff) begin
                                nxt_hs_mode = 1'b1;
                            end
                            nxt_state = ST_IDLE;
                            nxt_sda_oe = 1'b0;
                        end
                    end
                    ST_WRITE: begin
                        nxt_sda_oe = 1'b0;
                    end
                    ST_READ: begin
                        if (master_nack_ff) begin
                            nxt_state = ST_DONE;
                            nxt_sda_oe = 1'b0;
                        end else begin
                            nxt_tx = code_w;
                            nxt_sda_oe = ~code_w[7];
                        end
                    end
                    default: begin
                        nxt_sda_oe = 1'b0;
                    end
                endcase
            end else begin
                // Inside the byte
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
                if (state_ff == ST_READ) begin
                    // Next data bit driven while the clock is low
                    nxt_tx = {tx_ff[6:0], 1'b0};
                    nxt_sda_oe = ~tx_ff[6];
                end
            end
        end
    end

    // State registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= `BIT_FIRST;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            addr_hit_ff <= 1'b0;
            addr_read_ff <= 1'b0;
            mcode_ff <= 1'b0;
            master_nack_ff <= 1'b0;
            // Open drain: only ever drives low
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            hs_mode_o <= 1'b0;
            read_active_o <= 1'b0;
            ref_select_o <= `SEL_RESET;
            ext_clock_sel_o <= `CLK_RESET;
            polarity_select_o <= `POL_RESET;
            scan_mode_o <= `SCAN_RESET;
            chan_select_o <= `CS_RESET;
            input_mode_select_o <= `MODE_RESET;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            addr_hit_ff <= nxt_addr_hit;
            addr_read_ff <= nxt_addr_read;
            mcode_ff <= nxt_mcode;
            master_nack_ff <= nxt_master_nack;
            sda_o <= 1'b0;
            sda_oe_o <= nxt_sda_oe;
            hs_mode_o <= nxt_hs_mode;
            read_active_o <= (nxt_state == ST_READ);
            ref_select_o <= nxt_ref_select;
            ext_clock_sel_o <= nxt_ext_clock;
            polarity_select_o <= nxt_polarity;
            scan_mode_o <= nxt_scan_mode;
            chan_select_o <= nxt_chan_select;
            input_mode_select_o <= nxt_input_mode;
        end
    end

endmodule // adc_two_wire_slave_setup

// ### testbench/adc_slave_checker.sv
`timescale 1ns/1ps
// Pin and control-output checks beside the two-wire slave
module adc_slave_checker (
    input logic clk_i,
    input logic rst_i,
    input logic scl_i,
    input logic sda_i,
    input logic sda_o,
    input logic sda_oe_o,
    input logic [2:0] ref_select_o,
    input logic ext_clock_sel_o,
    input logic polarity_select_o,
    input logic [1:0] scan_mode_o,
    input logic [3:0] chan_select_o,
    input logic input_mode_select_o,
    input logic hs_mode_o,
    input logic read_active_o
);
    logic sda_last_ff; // Data pin one cycle back
    logic [3:0] stop_age_ff; // Window after a stop on the raw pins
    logic [7:0] oe_run_ff; // Length of the present pull-down run
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Raw pins are used, so the window must cover the synchroniser delay
    always @(posedge clk_i) begin
        sda_last_ff <= sda_i;
        if (rst_i) begin
            stop_age_ff <= 4'h0;
        end else if (scl_i && sda_i && !sda_last_ff) begin
            stop_age_ff <= 4'hc;
        end else if (stop_age_ff != 4'h0) begin
            stop_age_ff <= stop_age_ff - 4'h1;
        end
        oe_run_ff <= (sda_oe_o && !rst_i) ? oe_run_ff + 8'h1 : 8'h0;
    end
    // A pull-down lasts over the clock pulse it belongs to
    sequence pull_held;
        sda_oe_o [*6];
    endsequence
    a_open_drain: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("Data pin driven high");
    a_drive_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("Pull-down began while clock high");
    a_pull_spans_bit: assert property ($rose(sda_oe_o) |-> pull_held)
        else $error("Pull-down shorter than a clock pulse");
    a_pull_bounded: assert property (oe_run_ff < 8'ha0)
        else $error("Pull-down outlasts a byte");
    a_read_release: assert property ($fell(read_active_o) |-> !sda_oe_o)
        else $error("Data held after read end");
    a_hs_stop_only: assert property ($fell(hs_mode_o) |-> stop_age_ff != 4'h0)
        else $error("High-speed left without stop");
    a_hs_holds: assert property (hs_mode_o && stop_age_ff == 4'h0 |=> hs_mode_o)
        else $error("High-speed dropped early");
    a_ctrl_on_write: assert property ($changed({ref_select_o, ext_clock_sel_o,
        polarity_select_o, scan_mode_o, chan_select_o, input_mode_select_o})
        |-> !read_active_o && !scl_i)
        else $error("Control field moved outside a write");
    a_reset_state: assert property ($fell(rst_i) |-> !sda_oe_o && !hs_mode_o
        && {ref_select_o, ext_clock_sel_o, polarity_select_o} == 5'h00)
        else $error("Outputs not clear after reset");
endmodule // adc_slave_checker

bind adc_two_wire_slave_setup adc_slave_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .ref_select_o(ref_select_o), .ext_clock_sel_o(ext_clock_sel_o),
    .polarity_select_o(polarity_select_o), .scan_mode_o(scan_mode_o),
    .chan_select_o(chan_select_o), .input_mode_select_o(input_mode_select_o),
    .hs_mode_o(hs_mode_o), .read_active_o(read_active_o));

// ### testbench/bus_master_model.sv
`timescale 1ns/1ps
// Behavioural bus master: owns the clock pin, pulls the data pin low
module bus_master_model (
    input logic sda_i,
    output logic scl_o,
    output logic pull_o
);
    // Half the low phase, high phase twice it: 200 ns per bit by default
    real t_low = 50.0;
    // Bus idles high, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // one bit per pulse, data moves only while clock low
    task automatic put_bit(input logic b, output logic r);
        #(t_low) pull_o = ~b;
        #(t_low) scl_o = 1'b1;
        r = sda_i;
        #(2.0 * t_low) scl_o = 1'b0;
    endtask
    // data falls while clock high, also used as repeated start
    task automatic start_cond();
        #(t_low) pull_o = 1'b0;
        #(t_low) scl_o = 1'b1;
        #(t_low) pull_o = 1'b1;
        #(t_low) scl_o = 1'b0;
    endtask
    // data rises while clock high, both lines left high
    task automatic stop_cond();
        #(t_low) pull_o = 1'b1;
        #(t_low) scl_o = 1'b1;
        #(t_low) pull_o = 1'b0;
    endtask
    // eight bits out, then the line is released for the answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(b[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    // acknowledge to continue, release to end the read
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            b[i] = r;
        end
        put_bit(~more, r);
    endtask
endmodule // bus_master_model

// ### testbench/adc_two_wire_slave_setup_test.sv
`timescale 1ns/1ps
// Walks the slave through writes, refusals and reads with a master model
module adc_two_wire_slave_setup_test;
    logic clk_i = 1'b0; // Block clock, 40 MHz
    logic rst_i = 1'b1; // Held for eight cycles
    logic scl, pull, sda; // Master pins and resolved data wire
    logic [8:0] sample_i = 9'h000; // Difference sample fed to the coder
    logic sda_o, sda_oe_o, ext_clock_sel_o, polarity_select_o, input_mode_select_o;
    logic hs_mode_o, read_active_o, ack;
    logic [2:0] ref_select_o;
    logic [1:0] scan_mode_o;
    logic [3:0] chan_select_o;
    logic [7:0] rd, setup_seen, cfg_seen;
    int n_mismatch = 0;
    int cmp_count = 0;
    // Read cases: setup byte, config byte, sample, expected code
    logic [7:0] su[6] = '{8'h86, 8'h82, 8'h86, 8'h86, 8'h82, 8'h86};
    logic [7:0] cf[6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [8:0] sm[6] = '{9'h1c0, 9'h1c0, 9'h1c0, 9'h0a0, 9'h0a0, 9'h0a0};
    logic [7:0] ex[6] = '{8'h00, 8'h00, 8'hc0, 8'h7f, 8'ha0, 8'ha0};
    // Pull-up wins unless a party pulls low
    assign sda = ~(sda_oe_o | pull);
    assign setup_seen = {1'b0, ref_select_o, ext_clock_sel_o, polarity_select_o, 2'h0};
    assign cfg_seen = {1'b0, scan_mode_o, chan_select_o, input_mode_select_o};
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    bus_master_model i_master (.sda_i(sda), .scl_o(scl), .pull_o(pull));
    adc_two_wire_slave_setup #(.TWELVE_CH(0)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .sample_i(sample_i), .ref_select_o(ref_select_o),
        .ext_clock_sel_o(ext_clock_sel_o), .polarity_select_o(polarity_select_o),
        .scan_mode_o(scan_mode_o), .chan_select_o(chan_select_o),
        .input_mode_select_o(input_mode_select_o), .hs_mode_o(hs_mode_o),
        .read_active_o(read_active_o));
    // Ends the run with the counts and the verdict
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Counts each comparison, reports a mismatch at once
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Offset off the clock edge so pin changes never race the sampling
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #7;
    endtask
    // Write to address 1100100 with one or two control bytes
    task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input logic two);
        i_master.start_cond();
        i_master.send_byte(8'hc8, ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        i_master.send_byte(b0, ack);
        chk("byte ack", 8'h01, {7'h0, ack});
        if (two) begin
            i_master.send_byte(b1, ack);
            chk("byte ack", 8'h01, {7'h0, ack});
        end
        i_master.stop_cond();
        idle(10);
    endtask
    // Read two bytes, acknowledge the first, refuse the second
    task automatic rdb(input logic [7:0] exp);
        i_master.start_cond();
        i_master.send_byte(8'hc9, ack);
        idle(6);
        chk("read ack", 8'h01, {7'h0, ack});
        chk("read state", 8'h01, {7'h0, read_active_o});
        i_master.get_byte(1'b1, rd);
        chk("code", exp, rd);
        i_master.get_byte(1'b0, rd);
        chk("code again", exp, rd);
        idle(8);
        chk("released", 8'h00, {6'h0, read_active_o, sda_oe_o});
        i_master.stop_cond();
        idle(10);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        idle(4);
        chk("setup reset", 8'h00, setup_seen);
        chk("hs reset", 8'h00, {7'h0, hs_mode_o});
        i_master.start_cond();
        i_master.send_byte(8'hca, ack);
        chk("foreign ack", 8'h00, {7'h0, ack});
        i_master.stop_cond();
        idle(10);
        wr(8'hfa, 8'h5b, 1'b1);
        chk("setup", 8'h78, setup_seen);
        chk("config", 8'h5b, cfg_seen);
        i_master.t_low = 100.0;
        wr(8'h2c, 8'hf6, 1'b1);
        i_master.t_low = 50.0;
        chk("config first", 8'h2c, cfg_seen);
        chk("setup second", 8'h74, setup_seen);
        wr(8'h85, 8'h00, 1'b0);
        chk("setup kept", 8'h04, setup_seen);
        chk("config reset", 8'h00, cfg_seen);
        i_master.start_cond();
        for (int i = 0; i < 3; i++) i_master.put_bit(1'b1, ack);
        wr(8'h12, 8'h00, 1'b0);
        chk("config after restart", 8'h12, cfg_seen);
        i_master.start_cond();
        i_master.send_byte(8'h0d, ack);
        idle(8);
        chk("master code nack", 8'h00, {7'h0, ack});
        chk("hs entered", 8'h01, {7'h0, hs_mode_o});
        i_master.start_cond();
        i_master.send_byte(8'hc8, ack);
        chk("hs addr ack", 8'h01, {7'h0, ack});
        chk("hs kept", 8'h01, {7'h0, hs_mode_o});
        i_master.stop_cond();
        idle(10);
        chk("hs left", 8'h00, {7'h0, hs_mode_o});
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            sample_i <= sm[k];
            idle(2);
            wr(su[k], cf[k], 1'b1);
            rdb(ex[k]);
        end
        print_verdict();
    end
    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        print_verdict();
    end
endmodule // adc_two_wire_slave_setup_test
